// ==== hw/fsw_status_regs.sv ====
`include "fsw_cfg.svh"

module fsw_status_regs #(
  parameter int unsigned CNT_W = 16,
  parameter logic [CNT_W-1:0] SRW_CYCLES = `FSW_SRW_CYCLES,
  parameter logic [CNT_W-1:0] PROG_CYCLES = `FSW_PROG_CYCLES,
  parameter logic [CNT_W-1:0] ERASE_CYCLES = `FSW_ERASE_CYCLES,
  parameter logic [CNT_W-1:0] CHIP_CYCLES = `FSW_CHIP_CYCLES
) (
  // clocking and power
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic pwr_cycle,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic wp_n,
  input wire logic hold_rst_n,
  output logic so_q,
  output logic so_oe_n_q,
  // array side
  output logic array_go_q,
  output fsw_pkg::fsw_kind_e array_kind_q,
  output logic [23:0] array_addr_q,
  // configuration seen by the rest of the device
  output logic quad_io_enable_q,
  output logic [1:0] output_drive_strength_q,
  output logic low_power_state_q,
  output logic [2:0] security_lock_bits_q,
  output logic hold_pause_q
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic is_protected(input logic [23:0] addr,
                                        input logic [4:0] bp,
                                        input logic cmp);
    logic [4:0] shift;
    logic [23:0] mask;
    logic hit;
    shift = 5'd0;
    mask = 24'h000000;
    hit = 1'b0;
    if (bp[2:0] == 3'h7) begin
      hit = 1'b1;
    end else if (bp[2:0] != 3'h0) begin
      if (bp[4]) begin
        // small blocks stop growing at 32 KB
        shift = (bp[2]) ? 5'd15 : 5'd11 + {3'h0, bp[1:0]};
      end else begin
        shift = 5'd17 + {2'h0, bp[2:0]};
      end
      mask = 24'hffffff << shift;
      hit = bp[3] ? ((addr & mask) == 24'h000000)
                  : ((addr & mask) == mask);
    end
    return hit ^ cmp;
  endfunction

  function automatic logic [7:0] status_byte(
      input fsw_pkg::fsw_status_s s, input logic [7:0] cmd);
    logic [7:0] b;
    b = 8'h00;
    case (cmd)
      `FSW_CMD_RD1: b = {s.lock[0], s.bp, s.write_latch_flag, s.busy};
      `FSW_CMD_RD2: b = {s.erase_susp, s.cmp, s.lb, s.prog_susp,
                         s.qe, s.lock[1]};
      `FSW_CMD_RD3: b = {s.hold_rst_sel, s.drive, 2'h0, s.low_power,
                         2'h0};
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  fsw_pkg::fsw_pins_s pin_meta_q;
  fsw_pkg::fsw_pins_s pin_sync_q;
  fsw_pkg::fsw_pins_s pin_last_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_q <= fsw_pkg::fsw_pins_s'(`FSW_PINS_IDLE);
      pin_sync_q <= fsw_pkg::fsw_pins_s'(`FSW_PINS_IDLE);
      pin_last_q <= fsw_pkg::fsw_pins_s'(`FSW_PINS_IDLE);
    end else if (ce) begin
      pin_meta_q <= '{cs_n, sclk, si, wp_n, hold_rst_n};
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  fsw_pkg::fsw_op_e op_q;
  fsw_pkg::fsw_kind_e kind_q;
  logic [CNT_W-1:0] cnt_q;
  logic wel_q, erase_susp_q, prog_susp_q, rst_armed_q;
  logic [4:0] bp_q;
  logic [1:0] lock_q;
  logic cmp_q, hold_rst_sel_q;
  logic [2:0] bit_q, byte_q;
  logic [7:0] cmd_q, data_q, out_q;
  logic [23:0] addr_q, shift_q;

  // ----------------------------------------------------------------
  // pin functions and frame decode
  // ----------------------------------------------------------------
  logic hw_rst, hold_on, sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic frame_end, idle, srw_open, vol_clr;
  logic do_wren, do_write_disable_cmd, do_srw, do_prog, do_erase, do_chip;
  logic do_susp, do_resume, do_swrst;
  logic [CNT_W-1:0] erase_len;
  fsw_pkg::fsw_status_s st;
  logic [7:0] rd_byte;

  // in quad mode the shared pins are data lines only
  assign hw_rst = !quad_io_enable_q && hold_rst_sel_q
                  && !pin_sync_q.hold_n;
  assign hold_on = !quad_io_enable_q && !hold_rst_sel_q
                   && !pin_sync_q.hold_n && !pin_sync_q.cs_n;
  assign cs_fall = pin_last_q.cs_n && !pin_sync_q.cs_n;
  assign cs_rise = !pin_last_q.cs_n && pin_sync_q.cs_n;
  assign sclk_rise = !pin_last_q.sclk && pin_sync_q.sclk
                     && !pin_sync_q.cs_n && !hold_on;
  assign sclk_fall = pin_last_q.sclk && !pin_sync_q.sclk
                     && !pin_sync_q.cs_n && !hold_on;
  assign idle = (op_q == fsw_pkg::OP_IDLE);
  // a frame counts only when it ends on a byte boundary
  assign frame_end = cs_rise && (bit_q == 3'h0) && !hw_rst;

  always_comb begin
    // lock code 01 follows the protect pin unless it carries data
    case (lock_q)
      `FSW_LOCK_OPEN: srw_open = 1'b1;
      `FSW_LOCK_PIN: srw_open = pin_sync_q.wp_n
                               || quad_io_enable_q;
      default: srw_open = 1'b0;
    endcase
  end

  assign do_wren = frame_end && idle && byte_q == 3'h1
                   && cmd_q == `FSW_CMD_WREN;
  assign do_write_disable_cmd = frame_end && idle && byte_q == 3'h1
                   && cmd_q == `FSW_CMD_WRITE_DISABLE_CMD;
  assign do_srw = frame_end && idle && wel_q && srw_open
                  && byte_q == 3'h2
                  && (cmd_q == `FSW_CMD_WR1 || cmd_q == `FSW_CMD_WR2
                      || cmd_q == `FSW_CMD_WR3);
  assign do_prog = frame_end && idle && wel_q && byte_q >= 3'h5
                   && cmd_q == `FSW_CMD_PROG
                   && !is_protected(addr_q, bp_q, cmp_q);
  assign do_erase = frame_end && idle && wel_q && byte_q == 3'h4
                    && (cmd_q == `FSW_CMD_SECT || cmd_q == `FSW_CMD_BLK32
                        || cmd_q == `FSW_CMD_BLK64)
                    && !is_protected(addr_q, bp_q, cmp_q);
  assign do_chip = frame_end && idle && wel_q && byte_q == 3'h1
                   && (cmd_q == `FSW_CMD_CHIP_A
                       || cmd_q == `FSW_CMD_CHIP_B)
                   && ((bp_q[2:0] == 3'h0 && !cmp_q)
                       || (bp_q[2:0] == 3'h7 && cmp_q));
  assign do_susp = frame_end && byte_q == 3'h1
                   && cmd_q == `FSW_CMD_SUSPEND
                   && op_q == fsw_pkg::OP_RUN
                   && kind_q != fsw_pkg::KIND_SRW;
  assign do_resume = frame_end && byte_q == 3'h1
                     && cmd_q == `FSW_CMD_RESUME
                     && op_q == fsw_pkg::OP_SUSP;
  assign do_swrst = frame_end && byte_q == 3'h1 && rst_armed_q
                    && cmd_q == `FSW_CMD_RST;
  // volatile state returns to its power-on value
  assign vol_clr = pwr_cycle || hw_rst || do_swrst;
  assign erase_len = (cmd_q == `FSW_CMD_SECT) ? ERASE_CYCLES
                     : ERASE_CYCLES + ERASE_CYCLES;

  always_comb begin
    st = '0;
    st.hold_rst_sel = hold_rst_sel_q;
    st.drive = output_drive_strength_q;
    st.low_power = low_power_state_q;
    st.erase_susp = erase_susp_q;
    st.cmp = cmp_q;
    st.lb = security_lock_bits_q;
    st.prog_susp = prog_susp_q;
    st.qe = quad_io_enable_q;
    st.lock = lock_q;
    st.bp = bp_q;
    st.write_latch_flag = wel_q;
    st.busy = (op_q == fsw_pkg::OP_RUN);
  end

  assign rd_byte = status_byte(st, cmd_q);

  // ----------------------------------------------------------------
  // write latch and reset sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wel_q <= 1'b0;
    end else if (ce) begin
      if (vol_clr) begin
        wel_q <= 1'b0;
      end else if (do_wren) begin
        wel_q <= 1'b1;
      end else if (do_write_disable_cmd || do_srw || do_prog || do_erase || do_chip) begin
        wel_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rst_armed_q <= 1'b0;
    end else if (ce) begin
      if (hw_rst || pwr_cycle) begin
        rst_armed_q <= 1'b0;
      end else if (frame_end) begin
        rst_armed_q <= (byte_q == 3'h1 && cmd_q == `FSW_CMD_RST_EN);
      end
    end
  end

  // ----------------------------------------------------------------
  // operation timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      op_q <= fsw_pkg::OP_IDLE;
      kind_q <= fsw_pkg::KIND_SRW;
      cnt_q <= '0;
    end else if (ce) begin
      if (vol_clr) begin
        op_q <= fsw_pkg::OP_IDLE;
      end else begin
        case (op_q)
          fsw_pkg::OP_IDLE: begin
            if (do_srw || do_prog || do_erase || do_chip) begin
              op_q <= fsw_pkg::OP_RUN;
            end
            if (do_srw) begin
              kind_q <= fsw_pkg::KIND_SRW;
              cnt_q <= SRW_CYCLES;
            end else if (do_prog) begin
              kind_q <= fsw_pkg::KIND_PROG;
              cnt_q <= PROG_CYCLES;
            end else if (do_erase) begin
              kind_q <= fsw_pkg::KIND_ERASE;
              cnt_q <= erase_len;
            end else if (do_chip) begin
              kind_q <= fsw_pkg::KIND_CHIP;
              cnt_q <= CHIP_CYCLES;
            end
          end
          fsw_pkg::OP_RUN: begin
            if (do_susp) begin
              op_q <= fsw_pkg::OP_SUSP;
            end else if (cnt_q <= CNT_W'(1)) begin
              op_q <= fsw_pkg::OP_IDLE;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          fsw_pkg::OP_SUSP: begin
            if (do_resume) begin
              op_q <= fsw_pkg::OP_RUN;
            end
          end
          default: op_q <= fsw_pkg::OP_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // suspend flags, hardware only: status writes never reach them
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      erase_susp_q <= 1'b0;
      prog_susp_q <= 1'b0;
    end else if (ce) begin
      if (do_susp) begin
        erase_susp_q <= (kind_q != fsw_pkg::KIND_PROG);
        prog_susp_q <= (kind_q == fsw_pkg::KIND_PROG);
      end else if (do_resume || vol_clr) begin
        erase_susp_q <= 1'b0;
        prog_susp_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // non-volatile fields, kept across pwr_cycle except the supply lock code
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      bp_q <= 5'h00;
      lock_q <= `FSW_LOCK_OPEN;
      cmp_q <= 1'b0;
      quad_io_enable_q <= 1'b0;
      security_lock_bits_q <= 3'h0;
      output_drive_strength_q <= `FSW_DRV_DEFAULT;
      low_power_state_q <= 1'b0;
      hold_rst_sel_q <= 1'b0;
    end else if (ce) begin
      if (pwr_cycle) begin
        if (lock_q == `FSW_LOCK_SUPPLY) begin
          lock_q <= `FSW_LOCK_OPEN;
        end
      end else if (do_srw) begin
        case (cmd_q)
          `FSW_CMD_WR1: begin
            lock_q[0] <= data_q[`FSW_B1_LOCK_LO];
            bp_q <= data_q[`FSW_B1_BP_HI:`FSW_B1_BP_LO];
          end
          `FSW_CMD_WR2: begin
            lock_q[1] <= data_q[`FSW_B2_LOCK_HI];
            quad_io_enable_q <= data_q[`FSW_B2_QE];
            security_lock_bits_q <= security_lock_bits_q
              | data_q[`FSW_B2_LB_HI:`FSW_B2_LB_LO];
            cmp_q <= data_q[`FSW_B2_CMP];
          end
          `FSW_CMD_WR3: begin
            low_power_state_q <= data_q[`FSW_B3_LPE];
            output_drive_strength_q <=
              data_q[`FSW_B3_DRV_HI:`FSW_B3_DRV_LO];
            hold_rst_sel_q <= data_q[`FSW_B3_HOLD_RST];
          end
          default: lock_q <= lock_q;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // array requests and pause indication
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      array_go_q <= 1'b0;
      array_kind_q <= fsw_pkg::KIND_SRW;
      array_addr_q <= 24'h000000;
      hold_pause_q <= 1'b0;
    end else if (ce) begin
      array_go_q <= do_prog || do_erase || do_chip;
      if (do_prog) begin
        array_kind_q <= fsw_pkg::KIND_PROG;
      end else if (do_erase) begin
        array_kind_q <= fsw_pkg::KIND_ERASE;
      end else if (do_chip) begin
        array_kind_q <= fsw_pkg::KIND_CHIP;
      end
      if (do_prog || do_erase) begin
        array_addr_q <= addr_q;
      end
      hold_pause_q <= hold_on;
    end
  end

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_q <= 3'h0;
      byte_q <= 3'h0;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      addr_q <= 24'h000000;
      shift_q <= 24'h000000;
    end else if (ce) begin
      if (cs_fall || hw_rst) begin
        bit_q <= 3'h0;
        byte_q <= 3'h0;
        cmd_q <= 8'h00;
      end else if (sclk_rise) begin
        shift_q <= {shift_q[22:0], pin_sync_q.si};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          // byte count saturates, long programs stay valid
          if (byte_q != 3'h7) begin
            byte_q <= byte_q + 3'h1;
          end
          if (byte_q == 3'h0) begin
            cmd_q <= {shift_q[6:0], pin_sync_q.si};
          end
          if (byte_q == 3'h1) begin
            data_q <= {shift_q[6:0], pin_sync_q.si};
          end
          if (byte_q == 3'h3) begin
            addr_q <= {shift_q[22:0], pin_sync_q.si};
          end
        end
      end
    end
  end

  // live status is reloaded each byte so busy polling sees progress
  always_ff @(posedge clk) begin
    if (reset) begin
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
      out_q <= 8'h00;
    end else if (ce) begin
      if (pin_sync_q.cs_n || hold_on || hw_rst) begin
        so_oe_n_q <= 1'b1;
      end else if (sclk_fall && byte_q != 3'h0
                   && (cmd_q == `FSW_CMD_RD1 || cmd_q == `FSW_CMD_RD2
                       || cmd_q == `FSW_CMD_RD3)) begin
        so_oe_n_q <= 1'b0;
        if (bit_q == 3'h0) begin
          so_q <= rd_byte[7];
          out_q <= {rd_byte[6:0], 1'b0};
        end else begin
          so_q <= out_q[7];
          out_q <= {out_q[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// ==== hw/fsw_cfg.svh ====
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH
// Operation
// - busy bit set during program, erase, status write
// - write latch low refuses status write, program, erase
// - protect code blocks program and erase in region
// - protect code frozen while hardware lock applies
// - chip erase only for code 000/0 or 111/1
// - complement bit inverts the protected region
// - complement bit defaults low, joins region decode
// - lock code selects open, pin, supply or permanent
// - supply lock returns to open on power cycle
// - quad enable frees protect and hold pins
// - security lock bits set once, never clear
// - suspend sets erase or program suspended flag
// - resume, software reset, power cycle clear suspends
// - suspend flags ignore status writes
// - two bits select output drive, default half
// - select bit makes shared pin pause or reset
// - quad enable disables pause and reset functions
// - low power bit defaults low, shows mode
// - write latch cleared by power and write commands
// - hardware reset restores volatile bits, enters standby

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FSW_CMD_WREN      8'h06
`define FSW_CMD_WRITE_DISABLE_CMD      8'h04
`define FSW_CMD_RD1       8'h05
`define FSW_CMD_RD2       8'h35
`define FSW_CMD_RD3       8'h15
`define FSW_CMD_WR1       8'h01
`define FSW_CMD_WR2       8'h31
`define FSW_CMD_WR3       8'h11
`define FSW_CMD_PROG      8'h02
`define FSW_CMD_SECT      8'h20
`define FSW_CMD_BLK32     8'h52
`define FSW_CMD_BLK64     8'hd8
`define FSW_CMD_CHIP_A    8'hc7
`define FSW_CMD_CHIP_B    8'h60
`define FSW_CMD_SUSPEND   8'h75
`define FSW_CMD_RESUME    8'h7a
`define FSW_CMD_RST_EN    8'h66
`define FSW_CMD_RST       8'h99

// ----------------------------------------------------------------
// field positions within the three status bytes
// ----------------------------------------------------------------
`define FSW_B1_LOCK_LO    7
`define FSW_B1_BP_HI      6
`define FSW_B1_BP_LO      2
`define FSW_B2_LOCK_HI    0
`define FSW_B2_QE         1
`define FSW_B2_LB_HI      5
`define FSW_B2_LB_LO      3
`define FSW_B2_CMP        6
`define FSW_B3_LPE        2
`define FSW_B3_DRV_HI     6
`define FSW_B3_DRV_LO     5
`define FSW_B3_HOLD_RST   7

// ----------------------------------------------------------------
// reset values and lock codes
// ----------------------------------------------------------------
`define FSW_DRV_DEFAULT   2'h2
`define FSW_LOCK_OPEN     2'h0
`define FSW_LOCK_PIN      2'h1
`define FSW_LOCK_SUPPLY   2'h2
`define FSW_PINS_IDLE     5'h13

// ----------------------------------------------------------------
// operation lengths in clk cycles
// ----------------------------------------------------------------
`define FSW_SRW_CYCLES    16'h0020
`define FSW_PROG_CYCLES   16'h0040
`define FSW_ERASE_CYCLES  16'h0100
`define FSW_CHIP_CYCLES   16'h0400
`endif

// ==== hw/fsw_pkg.sv ====
package fsw_pkg;
  // pins as seen after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
    logic wp_n;
    logic hold_n;
  } fsw_pins_s;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_RUN  = 2'b01,
    OP_SUSP = 2'b10
  } fsw_op_e;

  typedef enum logic [1:0] {
    KIND_SRW   = 2'b00,
    KIND_PROG  = 2'b01,
    KIND_ERASE = 2'b10,
    KIND_CHIP  = 2'b11
  } fsw_kind_e;

  typedef struct packed {
    logic       hold_rst_sel;
    logic [1:0] drive;
    logic       low_power;
    logic       erase_susp;
    logic       cmp;
    logic [2:0] lb;
    logic       prog_susp;
    logic       qe;
    logic [1:0] lock;
    logic [4:0] bp;
    logic       write_latch_flag;
    logic       busy;
  } fsw_status_s;
endpackage

// ==== tb/fsw_status_regs_props.sv ====
module fsw_status_regs_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic cs_n,
  input wire logic array_go_q,
  input wire fsw_pkg::fsw_kind_e array_kind_q,
  input wire logic [23:0] array_addr_q,
  input wire logic quad_io_enable_q,
  input wire logic [1:0] output_drive_strength_q,
  input wire logic low_power_state_q,
  input wire logic [2:0] security_lock_bits_q,
  input wire logic hold_pause_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_go_one_cycle: assert property (array_go_q |=> !array_go_q)
    else $error("array start pulse longer than one cycle");
  a_go_not_status: assert property (
    array_go_q |-> array_kind_q != fsw_pkg::KIND_SRW)
    else $error("array start with status kind");
  a_go_after_frame: assert property (array_go_q |-> cs_n)
    else $error("array start inside a frame");
  a_start_holds: assert property (
    $changed(array_kind_q) || $changed(array_addr_q) |-> array_go_q)
    else $error("array kind or address moved without start");
  a_lock_sticky: assert property (
    !$past(reset) |-> ($past(security_lock_bits_q) &
    ~security_lock_bits_q) == 3'h0)
    else $error("security lock bit cleared");
  a_reset_values: assert property (
    $fell(reset) |-> output_drive_strength_q == 2'h2 &&
    !quad_io_enable_q && !low_power_state_q)
    else $error("configuration not at defaults after reset");
  a_quad_no_hold: assert property (
    quad_io_enable_q |-> !hold_pause_q)
    else $error("pause active with quad enabled");
  a_cfg_frame_end: assert property (
    $changed({quad_io_enable_q, output_drive_strength_q,
    low_power_state_q}) |-> cs_n)
    else $error("configuration moved inside a frame");
endmodule

bind fsw_status_regs fsw_status_regs_props i_props (
  .clk(clk), .reset(reset), .cs_n(cs_n), .array_go_q(array_go_q),
  .array_kind_q(array_kind_q), .array_addr_q(array_addr_q),
  .quad_io_enable_q(quad_io_enable_q),
  .output_drive_strength_q(output_drive_strength_q),
  .low_power_state_q(low_power_state_q),
  .security_lock_bits_q(security_lock_bits_q),
  .hold_pause_q(hold_pause_q)
);

// ==== tb/fsw_host_model.sv ====
module fsw_host_model (
  // clock
  input wire logic clk,
  // serial link
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so_q,
  input wire logic so_oe_n_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    last_q = 1'b0;
  end

  // half of the 800 ns link period; sclk stands low between frames
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // a released output reads as the inverse of its last level
  task automatic xfer(input logic [7:0] b [5], input int n,
                      input int nrd, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < 8 * (n + nrd); i++) begin
      si = (i < 8 * n) ? b[i / 8][7 - i % 8] : ~si;
      half();
      sclk = 1'b1;
      half();
      if (i >= 8 * n) begin
        last_q = so_oe_n_q ? ~last_q : so_q;
        rd = {rd[6:0], last_q};
      end
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ==== tb/fsw_status_regs_test.sv ====
`include "fsw_cfg.svh"

module fsw_status_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, ce, pwr_cycle, wp_n, hold_rst_n, cs_n, sclk, si;
  logic so_q, so_oe_n_q, array_go_q, quad_q, lpm_q, hold_q;
  fsw_pkg::fsw_kind_e kind_q;
  logic [23:0] addr_q;
  logic [1:0] drv_q;
  logic [2:0] lb_q;
  logic [7:0] rd;
  int n_mismatch, checked;
  int n_go = 0;
  logic [7:0] t_s1 [8] = '{8'h04, 8'h04, 8'h04, 8'h00,
                           8'h04, 8'h04, 8'h1c, 8'h00};
  logic [7:0] t_op [8] = '{8'h20, 8'h20, 8'hc7, 8'h60,
                           8'h52, 8'hd8, 8'hc7, 8'h02};
  logic [23:0] t_ad [8] = '{24'hfc0000, 24'hfb0000, 24'h000000,
                            24'h000000, 24'h000000, 24'hfc0000,
                            24'h000000, 24'h000100};
  int t_n [8] = '{4, 4, 1, 1, 4, 4, 1, 5};
  int t_go [8] = '{0, 1, 0, 1, 0, 1, 1, 0};
  logic [1:0] t_kd [8] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h3,
                           2'h1};

  // long enough that busy outlasts a status read frame
  fsw_status_regs #(.PROG_CYCLES(16'h0400), .ERASE_CYCLES(16'h0400),
    .CHIP_CYCLES(16'h0800)) i_dut (
    .clk(clk), .reset(reset), .ce(ce), .pwr_cycle(pwr_cycle),
    .cs_n(cs_n), .sclk(sclk), .si(si), .wp_n(wp_n),
    .hold_rst_n(hold_rst_n), .so_q(so_q), .so_oe_n_q(so_oe_n_q),
    .array_go_q(array_go_q), .array_kind_q(kind_q),
    .array_addr_q(addr_q), .quad_io_enable_q(quad_q),
    .output_drive_strength_q(drv_q), .low_power_state_q(lpm_q),
    .security_lock_bits_q(lb_q), .hold_pause_q(hold_q));

  fsw_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so_q(so_q), .so_oe_n_q(so_oe_n_q));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) if (array_go_q === 1'b1) n_go <= n_go + 1;

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] c, d, input int n);
    i_host.xfer('{c, d, 8'h00, 8'h00, 8'h00}, n, 0, rd);
  endtask

  task automatic rdc(input string nm, input logic [7:0] c, exp);
    i_host.xfer('{c, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1, rd);
    chk(nm, {16'h0, rd}, {16'h0, exp});
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 40; k++) begin
      i_host.xfer('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1, rd);
      if (rd[0] === 1'b0) break;
    end
    chk("idle", {23'h0, rd[0]}, 24'h0);
  endtask

  task automatic we(input logic [7:0] c, d);
    send(`FSW_CMD_WREN, 8'h00, 1);
    send(c, d, 2);
    wait_idle();
  endtask

  task automatic pin_reset();
    hold_rst_n = 1'b0;
    repeat (20) @(negedge clk);
    hold_rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {ce, reset, pwr_cycle, wp_n, hold_rst_n} = 5'h19;
    {n_mismatch, checked} = 64'h0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    rdc("sr1", 8'h05, 8'h00);
    rdc("sr2", 8'h35, 8'h00);
    rdc("sr3", 8'h15, 8'h40);
    send(8'h01, 8'h1c, 2);
    rdc("nowel", 8'h05, 8'h00);
    send(`FSW_CMD_WREN, 8'h00, 1);
    rdc("wel", 8'h05, 8'h02);
    send(`FSW_CMD_WRITE_DISABLE_CMD, 8'h00, 1);
    rdc("write_disable_cmd", 8'h05, 8'h00);
    // pause the shared pin inside a read frame; the read data is dropped
    fork
      i_host.xfer('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1, rd);
      begin
        repeat (40) @(negedge clk);
        hold_rst_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("pause", {23'h0, hold_q}, 24'h1);
        hold_rst_n = 1'b1;
      end
    join
    send(`FSW_CMD_WREN, 8'h00, 1);
    i_host.xfer('{8'h20, 8'h12, 8'h30, 8'h00, 8'h00}, 4, 0, rd);
    rdc("busy", 8'h05, 8'h01);
    send(`FSW_CMD_SUSPEND, 8'h00, 1);
    rdc("esus", 8'h35, 8'h80);
    send(`FSW_CMD_RESUME, 8'h00, 1);
    rdc("resume", 8'h35, 8'h00);
    wait_idle();
    send(`FSW_CMD_WREN, 8'h00, 1);
    i_host.xfer('{8'h02, 8'h00, 8'h01, 8'h00, 8'h5a}, 5, 0, rd);
    send(`FSW_CMD_SUSPEND, 8'h00, 1);
    rdc("psus", 8'h35, 8'h04);
    send(`FSW_CMD_RST_EN, 8'h00, 1);
    send(`FSW_CMD_RST, 8'h00, 1);
    rdc("swrst", 8'h35, 8'h00);
    for (int i = 0; i < 8; i++) begin
      int g;
      we(8'h01, t_s1[i]);
      we(8'h31, (i > 3) ? 8'h40 : 8'h00);
      g = n_go;
      send(`FSW_CMD_WREN, 8'h00, 1);
      i_host.xfer('{t_op[i], t_ad[i][23:16], t_ad[i][15:8], t_ad[i][7:0],
                    8'ha5}, t_n[i], 0, rd);
      chk("go", 24'(n_go - g), 24'(t_go[i]));
      if (t_go[i] == 1)
        chk("kind", {22'h0, kind_q}, {22'h0, t_kd[i]});
      if (t_n[i] == 4 && t_go[i] == 1) chk("addr", addr_q, t_ad[i]);
      wait_idle();
    end
    we(8'h01, 8'h80);
    wp_n = 1'b0;
    we(8'h01, 8'h84);
    rdc("lockpin", 8'h05, 8'h82);
    wp_n = 1'b1;
    we(8'h01, 8'h84);
    rdc("unlock", 8'h05, 8'h84);
    we(8'h01, 8'h00);
    we(8'h31, 8'h01);
    we(8'h01, 8'h08);
    rdc("supply", 8'h05, 8'h02);
    pwr_cycle = 1'b1;
    @(negedge clk);
    pwr_cycle = 1'b0;
    rdc("pwrlock", 8'h35, 8'h00);
    rdc("pwrwel", 8'h05, 8'h00);
    we(8'h31, 8'h08);
    we(8'h31, 8'h00);
    rdc("otp", 8'h35, 8'h08);
    chk("lbpin", {21'h0, lb_q}, 24'h1);
    we(8'h11, 8'hff);
    rdc("sr3w", 8'h15, 8'he4);
    chk("drv", {22'h0, drv_q}, 24'h3);
    we(8'h31, 8'h0a);
    chk("quad", {23'h0, quad_q}, 24'h1);
    send(`FSW_CMD_WREN, 8'h00, 1);
    pin_reset();
    rdc("quadrst", 8'h05, 8'h02);
    we(8'h31, 8'h08);
    send(`FSW_CMD_WREN, 8'h00, 1);
    pin_reset();
    rdc("pinrst", 8'h05, 8'h00);
    print_verdict();
  end
endmodule
